// ### design/usmc_pkg.sv
// Package of constants for the ULPI serial mode control block
//----------------------------------------------------------------
//----------------------------------------------------------------
package usmc_pkg;
	// Reset values of the control bits
	localparam logic THREE_SEL_RST = 1'h0;
	localparam logic SIX_SEL_RST = 1'h0;
	localparam logic KEEPALIVE_RST = 1'h0;
	// Interface mode encoding, Gray order parallel -> three -> six
	typedef enum logic [1:0] {
		USMC_PAR = 2'h0,
		USMC_THREE = 2'h1,
		USMC_SIX = 2'h3
	} usmc_mode_t;
	// Reset values of the mode, lane mask and clock power
	localparam usmc_mode_t MODE_RST = USMC_PAR;
	localparam logic [5:0] LANE_RST = 6'h00;
	localparam logic CLK_PWR_RST = 1'h1;
	// Width of the serial data path in each mode
	localparam int THREE_WIDTH = 3;
	localparam int SIX_WIDTH = 6;
endpackage

// ### design/usmc_clk_gate.sv
// Internal clock power decision for serial modes
`timescale 1ns/1ps
`default_nettype none
module usmc_clk_gate (
	input wire logic clk_sys_in, // System clock
	input wire logic reset_in, // Async reset, active high
	input wire logic serial_active_in, // A serial mode is active
	input wire logic suspend_low_ctrl_in, // Suspend-low control bit
	input wire logic keepalive_in, // Keep-alive setting
	output logic clk_power_out // Internal clock powered
);
	logic pwr_reg;
	logic pwr_next;

	// Setting counts only in serial mode with suspend-low at 1
	always_comb begin
		pwr_next = 1'h1;
		if (serial_active_in && suspend_low_ctrl_in) begin
			pwr_next = keepalive_in;
		end else if (serial_active_in) begin
			pwr_next = 1'h0;
		end
	end

	// Register the power state
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			pwr_reg <= usmc_pkg::CLK_PWR_RST;
		end else begin
			pwr_reg <= pwr_next;
		end
	end

	// Power decision straight from its flip-flop
	assign clk_power_out = pwr_reg;

	// Outside serial modes the clock always runs
	keepalive_ignored_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		!serial_active_in |=> clk_power_out)
		else $error("clock unpowered outside serial mode");
	// Serial mode with suspend-low set follows the setting
	keepalive_honoured_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		serial_active_in && suspend_low_ctrl_in |=> clk_power_out == $past(keepalive_in))
		else $error("keep-alive setting not honoured");
	// Serial mode with suspend-low clear falls back to unpowered
	clock_off_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		serial_active_in && !suspend_low_ctrl_in |=> !clk_power_out)
		else $error("keep-alive not ignored with suspend-low clear");
endmodule
`default_nettype wire

// ### design/usmc_top.sv
// ULPI serial mode control: mode selects, auto-clear and clock power
`timescale 1ns/1ps
`default_nettype none
module usmc_top (
	input wire logic clk_sys_in, // System clock, 200 MHz
	input wire logic reset_in, // Async reset, active high
	input wire logic three_wire_fsls_select_wr_in, // Write strobe for three-wire select
	input wire logic three_wire_fsls_select_in, // Value written to three-wire select
	input wire logic six_wire_fsls_select_wr_in, // Write strobe for six-wire select
	input wire logic six_wire_fsls_select_in, // Value written to six-wire select
	input wire logic serial_clock_keepalive_wr_in, // Write strobe for keep-alive
	input wire logic serial_clock_keepalive_in, // Value written to keep-alive
	input wire logic suspend_low_ctrl_in, // Suspend-low control level
	input wire logic three_wire_exit_in, // Pulse: 3-pin serial mode exited
	output logic three_wire_fsls_select_out, // Three-wire select readback
	output logic six_wire_fsls_select_out, // Six-wire select readback
	output logic serial_clock_keepalive_out, // Keep-alive readback
	output logic [1:0] ulpi_mode_out, // Active interface mode
	output logic [5:0] serial_lane_en_out, // Data lanes used serially
	output logic clk_power_out // Internal clock powered
);
	logic three_reg, three_next;
	logic six_reg, six_next;
	logic keep_reg, keep_next;
	usmc_pkg::usmc_mode_t mode_reg, mode_next;
	logic [5:0] lane_reg, lane_next;

	//----------------------------------------------------------------
	// Lane decode
	//----------------------------------------------------------------
	// Lane mask for a given mode
	function automatic logic [5:0] lane_mask(input usmc_pkg::usmc_mode_t m);
		case (m)
			usmc_pkg::USMC_THREE: lane_mask = 6'((1 << usmc_pkg::THREE_WIDTH) - 1);
			usmc_pkg::USMC_SIX: lane_mask = 6'((1 << usmc_pkg::SIX_WIDTH) - 1);
			default: lane_mask = 6'h00;
		endcase
	endfunction

	//----------------------------------------------------------------
	// Control bits
	//----------------------------------------------------------------
	// Link writes; the device clears three-wire select on exit
	always_comb begin
		three_next = three_reg;
		six_next = six_reg;
		keep_next = keep_reg;
		if (three_wire_exit_in && mode_reg == usmc_pkg::USMC_THREE) begin
			three_next = 1'h0;
		end
		if (three_wire_fsls_select_wr_in) begin
			three_next = three_wire_fsls_select_in;
		end
		if (six_wire_fsls_select_wr_in) begin
			six_next = six_wire_fsls_select_in;
		end
		if (serial_clock_keepalive_wr_in) begin
			keep_next = serial_clock_keepalive_in;
		end
	end

	// Register the control bits
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			three_reg <= usmc_pkg::THREE_SEL_RST;
			six_reg <= usmc_pkg::SIX_SEL_RST;
			keep_reg <= usmc_pkg::KEEPALIVE_RST;
		end else begin
			three_reg <= three_next;
			six_reg <= six_next;
			keep_reg <= keep_next;
		end
	end

	//----------------------------------------------------------------
	// Mode machine
	//----------------------------------------------------------------
	// Six-wire wins if the link breaks the one-select rule
	always_comb begin
		case ({six_reg, three_reg})
			2'h1: mode_next = usmc_pkg::USMC_THREE;
			2'h2, 2'h3: mode_next = usmc_pkg::USMC_SIX;
			default: mode_next = usmc_pkg::USMC_PAR;
		endcase
		lane_next = lane_mask(mode_next);
	end

	// Register mode and lane mask
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			mode_reg <= usmc_pkg::MODE_RST;
			lane_reg <= usmc_pkg::LANE_RST;
		end else begin
			mode_reg <= mode_next;
			lane_reg <= lane_next;
		end
	end

	//----------------------------------------------------------------
	// Clock power
	//----------------------------------------------------------------
	// Serial whenever the mode register leaves the parallel path
	usmc_clk_gate u_clk_gate (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.serial_active_in(mode_reg != usmc_pkg::USMC_PAR),
		.suspend_low_ctrl_in(suspend_low_ctrl_in),
		.keepalive_in(keep_reg),
		.clk_power_out(clk_power_out)
	);

	//----------------------------------------------------------------
	// Outputs
	//----------------------------------------------------------------
	// Readbacks, mode and lanes straight from flip-flops
	assign three_wire_fsls_select_out = three_reg;
	assign six_wire_fsls_select_out = six_reg;
	assign serial_clock_keepalive_out = keep_reg;
	assign ulpi_mode_out = mode_reg;
	assign serial_lane_en_out = lane_reg;

	//----------------------------------------------------------------
	// Checks: control bits
	//----------------------------------------------------------------
	// A three-wire write lands next cycle, even against an exit
	three_write_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		three_wire_fsls_select_wr_in
		|=> three_wire_fsls_select_out == $past(three_wire_fsls_select_in))
		else $error("three-wire select write lost");

	// Exit clears three-wire select unless a write collides
	three_autoclear_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		three_wire_exit_in && mode_reg == usmc_pkg::USMC_THREE
		&& !three_wire_fsls_select_wr_in |=> !three_wire_fsls_select_out)
		else $error("three-wire select not cleared on exit");

	// Without a write or a live exit the select holds
	three_hold_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		!three_wire_fsls_select_wr_in
		&& !(three_wire_exit_in && ulpi_mode_out == 2'h1)
		|=> $stable(three_wire_fsls_select_out))
		else $error("three-wire select changed by itself");

	// Exit outside three-wire mode is refused
	exit_refused_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		three_wire_exit_in && ulpi_mode_out != 2'h1
		&& !three_wire_fsls_select_wr_in |=> $stable(three_wire_fsls_select_out))
		else $error("exit acted outside three-wire mode");

	// A six-wire write lands next cycle
	six_write_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		six_wire_fsls_select_wr_in
		|=> six_wire_fsls_select_out == $past(six_wire_fsls_select_in))
		else $error("six-wire select write lost");

	// Six-wire select only moves on a write
	six_hold_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		!six_wire_fsls_select_wr_in |=> $stable(six_wire_fsls_select_out))
		else $error("six-wire select changed without write");

	// Keep-alive write lands next cycle
	keep_write_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		serial_clock_keepalive_wr_in |=> keep_reg == $past(serial_clock_keepalive_in))
		else $error("keep-alive write lost");

	// Keep-alive only moves on a write
	keep_hold_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		!serial_clock_keepalive_wr_in |=> $stable(keep_reg))
		else $error("keep-alive changed without write");

	//----------------------------------------------------------------
	// Checks: mode and lanes
	//----------------------------------------------------------------
	// Three-wire select alone picks the 3-bit serial path
	three_mode_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		three_reg && !six_reg |=> ulpi_mode_out == 2'h1 && serial_lane_en_out == 6'h07)
		else $error("three-wire mode not entered");

	// Six-wire select picks the 6-bit path, even beside three-wire
	six_mode_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		six_reg |=> ulpi_mode_out == 2'h3 && serial_lane_en_out == 6'h3F)
		else $error("six-wire mode not entered");

	// No select keeps the parallel path
	parallel_mode_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		!three_reg && !six_reg |=> ulpi_mode_out == 2'h0 && serial_lane_en_out == 6'h00)
		else $error("parallel path not used");

	// Three-wire mode hands exactly three lanes over
	three_lanes_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		ulpi_mode_out == 2'h1 |-> serial_lane_en_out == 6'h07)
		else $error("three-wire lane mask wrong");

	// Six-wire mode hands all six lanes over
	six_lanes_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		ulpi_mode_out == 2'h3 |-> serial_lane_en_out == 6'h3F)
		else $error("six-wire lane mask wrong");

	// Parallel mode hands no lane to the serial path
	par_lanes_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		ulpi_mode_out == 2'h0 |-> serial_lane_en_out == 6'h00)
		else $error("parallel lane mask wrong");

	// A lone three-wire write reaches the mode two cycles on
	three_enter_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		three_wire_fsls_select_wr_in && three_wire_fsls_select_in
		&& !six_wire_fsls_select_out && !six_wire_fsls_select_wr_in
		|-> ##2 ulpi_mode_out == 2'h1)
		else $error("three-wire mode late");

	// A six-wire write reaches the mode two cycles on
	six_enter_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		six_wire_fsls_select_wr_in && six_wire_fsls_select_in |-> ##2 ulpi_mode_out == 2'h3)
		else $error("six-wire mode late");

	// Exit from three-wire mode returns to the parallel path
	par_return_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		three_wire_exit_in && ulpi_mode_out == 2'h1 && !three_wire_fsls_select_wr_in
		&& !six_wire_fsls_select_out && !six_wire_fsls_select_wr_in
		|-> ##2 ulpi_mode_out == 2'h0 && serial_lane_en_out == 6'h00)
		else $error("parallel path not restored on exit");

	// Keep-alive touches only the clock, never the mode
	keep_no_mode_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$stable(three_wire_fsls_select_out) && $stable(six_wire_fsls_select_out)
		|=> $stable(ulpi_mode_out) && $stable(serial_lane_en_out))
		else $error("mode moved without a select change");
endmodule
`default_nettype wire

// ### sim/usmc_link_model.sv
// Link controller model: one-cycle control writes
`timescale 1ns/1ps
`default_nettype none
module usmc_link_model (
	input wire logic clk_sys_in, // System clock
	output logic [2:0] wr_out, // Strobes: three, six, keep-alive
	output logic [2:0] data_out, // Written values
	output logic exit_out // Three-wire exit pulse
);
	// Idle at time zero
	initial begin
		wr_out = 3'h0;
		data_out = 3'h0;
		exit_out = 1'h0;
	end
	// One transfer: held through one edge, then released
	task automatic put(input logic [2:0] wr, input logic [2:0] d, input logic ex);
		@(posedge clk_sys_in);
		#1;
		wr_out = wr;
		data_out = d;
		exit_out = ex;
		@(posedge clk_sys_in);
		#1;
		wr_out = 3'h0;
		data_out = ~d; // Released data shows no stale value
		exit_out = 1'h0;
	endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Testbench: link writes and checks of the mode and clock outputs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_sys_in, reset_in, suspend_low_ctrl_in, ex, sel3, sel6, ka, pwr;
	logic [2:0] wr, dat;
	logic [1:0] mode;
	logic [5:0] lanes;
	logic [11:0] seen;
	int failures = 0;
	int check_count = 0;
	// All outputs packed for one compare
	assign seen = {sel3, sel6, ka, mode, lanes, pwr};
	usmc_link_model i_link (.clk_sys_in(clk_sys_in), .wr_out(wr), .data_out(dat), .exit_out(ex));
	usmc_top i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.three_wire_fsls_select_wr_in(wr[0]), .three_wire_fsls_select_in(dat[0]),
		.six_wire_fsls_select_wr_in(wr[1]), .six_wire_fsls_select_in(dat[1]),
		.serial_clock_keepalive_wr_in(wr[2]), .serial_clock_keepalive_in(dat[2]),
		.suspend_low_ctrl_in(suspend_low_ctrl_in), .three_wire_exit_in(ex),
		.three_wire_fsls_select_out(sel3), .six_wire_fsls_select_out(sel6),
		.serial_clock_keepalive_out(ka), .ulpi_mode_out(mode),
		.serial_lane_en_out(lanes), .clk_power_out(pwr));
	// Clock, 5 ns period
	initial begin
		clk_sys_in = 1'h0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	// Compare and count
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD outputs expected %h seen %h", exp, got);
		end
	endtask
	// One transfer, then wait for the clock decision to land
	task automatic step(input logic [2:0] w, input logic [2:0] d, input logic e,
		input logic [11:0] exp);
		i_link.put(w, d, e);
		repeat (3) @(posedge clk_sys_in);
		#1;
		chk(seen, exp);
	endtask
	// Verdict
	task automatic test_done;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		reset_in = 1'h1;
		suspend_low_ctrl_in = 1'h1;
		repeat (4) @(posedge clk_sys_in);
		#1;
		reset_in = 1'h0;
		chk(seen, 12'h001);
		step(3'h5, 3'h1, 1'h0, 12'h88E);
		step(3'h4, 3'h4, 1'h0, 12'hA8F);
		suspend_low_ctrl_in = 1'h0;
		step(3'h0, 3'h0, 1'h0, 12'hA8E);
		suspend_low_ctrl_in = 1'h1;
		step(3'h0, 3'h0, 1'h1, 12'h201);
		step(3'h2, 3'h2, 1'h0, 12'h7FF);
		step(3'h0, 3'h0, 1'h1, 12'h7FF);
		step(3'h4, 3'h0, 1'h0, 12'h5FE);
		step(3'h2, 3'h0, 1'h0, 12'h001);
		step(3'h1, 3'h1, 1'h0, 12'h88E);
		step(3'h1, 3'h1, 1'h1, 12'h88E);
		test_done;
	end
	// Watchdog
	initial begin
		#2000;
		failures++;
		test_done;
	end
endmodule
`default_nettype wire
